// [src/keypad_wake_interrupt.sv]
// Keypad wake interrupt: per-pin enables, sticky flag, interrupt and wake outputs.
// Assumes AXI4-Lite master on clk; keypad pins pulled high, pressed keys pull low.
// Function
// R1: All enabled port pins merge into one shared interrupt source.
// R2: Eight-bit enable register; bit n enables pin n, any combination.
// R3: Flag sets whenever an enabled pin is low while function active.
// R4: Interrupt requested from flag only when keypad interrupt enabled.
// R5: Software clears the flag; hardware never clears it itself.
// R6: Interrupt wakes the CPU from both Idle and Power Down.
// R7: Pin enables are ignored until the keypad interrupt is enabled.
// R8: Pins are synchronised; the raw-pin async detect still needs a clk edge to raise wake.
`timescale 1ns/1ns
`default_nettype none
module keypad_wake_interrupt #(
  parameter int unsigned PINS = keypad_wake_pkg::PIN_COUNT
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [PINS-1:0] keypad_pins,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             wake_request
);
  if (PINS != 8) begin : g_bad_pins
    $error("keypad_wake_interrupt serves exactly 8 pins");
  end

  logic [1:0] rst_sync_q;
  logic       rst_local_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_local_n = rst_sync_q[1];

  pin_sync_if #(.WIDTH(PINS)) pin_bus ();
  pin_synchronizer #(.WIDTH(PINS)) u_sync (
    .clk   (clk),
    .rst_n (rst_local_n),
    .pins  (keypad_pins),
    .sync  (pin_bus.source)
  );

  typedef struct packed {
    logic [7:0]  pin_enable;
    logic        irq_enable;
    logic        flag;
    logic        irq_mask;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
    logic        wake;
  } ctrl_s;
  ctrl_s st_q;
  ctrl_s st_d;

  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_fire;
  logic        press;
  logic        clear_flag;
  logic        async_press;

  // Idle and Power Down wake: asynchronous press on the raw pins, registered into wake at the next clk edge
  assign async_press = st_q.irq_enable & (|(st_q.pin_enable & ~keypad_pins)); // R6 R8

  always_comb begin
    st_d       = st_q;
    wr_addr    = st_q.aw_held ? st_q.aw_addr : s_axi_awaddr;
    wr_data    = st_q.w_held ? st_q.w_data : s_axi_wdata;
    wr_strb    = st_q.w_held ? st_q.w_strb : s_axi_wstrb;
    wr_fire    = 1'b0;
    clear_flag = 1'b0;
    // Enables only matter once the function itself is switched on
    press      = st_q.irq_enable & (|(st_q.pin_enable & ~pin_bus.level)); // R1 R3 R7

    if (s_axi_awvalid && !st_q.aw_held && !st_q.bvalid) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_held && !st_q.bvalid) begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if ((st_q.aw_held || (s_axi_awvalid && !st_q.bvalid)) &&
        (st_q.w_held || (s_axi_wvalid && !st_q.bvalid)) && !st_q.bvalid) begin
      wr_fire      = 1'b1;
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = keypad_wake_pkg::RESP_OKAY;
      unique case (wr_addr)
        keypad_wake_pkg::OFF_PIN_ENABLE: begin
          if (wr_strb[0]) begin
            st_d.pin_enable = wr_data[7:0]; // R2
          end
        end
        keypad_wake_pkg::OFF_AUX_CONTROL: begin
          if (wr_strb[0]) begin
            st_d.irq_enable = wr_data[keypad_wake_pkg::AUX_IRQ_EN_BIT];
            clear_flag = ~wr_data[keypad_wake_pkg::AUX_FLAG_BIT]; // R5
          end
        end
        keypad_wake_pkg::OFF_IRQ_STATUS: begin
          if (wr_strb[0]) begin
            clear_flag = wr_data[keypad_wake_pkg::STAT_FLAG_BIT]; // R5
          end
        end
        keypad_wake_pkg::OFF_IRQ_MASK: begin
          if (wr_strb[0]) begin
            st_d.irq_mask = wr_data[keypad_wake_pkg::STAT_FLAG_BIT];
          end
        end
        keypad_wake_pkg::OFF_PIN_LEVEL: begin
          st_d.bresp = keypad_wake_pkg::RESP_OKAY;
        end
        default: begin
          st_d.bresp = keypad_wake_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // A press in the clearing cycle wins, so no key event is lost
    if (press) begin
      st_d.flag = 1'b1; // R3
    end else if (clear_flag) begin
      st_d.flag = 1'b0; // R5
    end

    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = keypad_wake_pkg::RESP_OKAY;
      st_d.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        keypad_wake_pkg::OFF_PIN_ENABLE: begin
          st_d.rdata[7:0] = st_q.pin_enable;
        end
        keypad_wake_pkg::OFF_AUX_CONTROL: begin
          st_d.rdata[keypad_wake_pkg::AUX_IRQ_EN_BIT] = st_q.irq_enable;
          st_d.rdata[keypad_wake_pkg::AUX_FLAG_BIT]   = st_q.flag;
        end
        keypad_wake_pkg::OFF_IRQ_STATUS: begin
          st_d.rdata[keypad_wake_pkg::STAT_FLAG_BIT] = st_q.flag;
        end
        keypad_wake_pkg::OFF_IRQ_MASK: begin
          st_d.rdata[keypad_wake_pkg::STAT_FLAG_BIT] = st_q.irq_mask;
        end
        keypad_wake_pkg::OFF_PIN_LEVEL: begin
          st_d.rdata[7:0] = pin_bus.level;
        end
        default: begin
          st_d.rresp = keypad_wake_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end

    // Flag is only recorded unless the function and mask both allow it
    st_d.irq  = st_d.flag & st_d.irq_enable & st_d.irq_mask; // R4
    st_d.wake = st_d.irq | async_press; // R6
  end

  always_ff @(posedge clk or negedge rst_local_n) begin
    if (!rst_local_n) begin
      st_q            <= '0;
      st_q.pin_enable <= keypad_wake_pkg::PIN_ENABLE_RESET;
      st_q.irq_enable <= keypad_wake_pkg::AUX_IRQ_EN_RESET;
      st_q.irq_mask   <= keypad_wake_pkg::IRQ_MASK_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = ~st_q.aw_held & ~st_q.bvalid;
  assign s_axi_wready  = ~st_q.w_held & ~st_q.bvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = ~st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign irq           = st_q.irq;
  // Registered wake copy; async_press feeds it so a press is caught next edge
  assign wake_request  = st_q.wake;
endmodule // keypad_wake_interrupt
`default_nettype wire

// [inc/keypad_wake_pkg.sv]
// Constants, register map and field layout for the keypad wake interrupt block.
// Assumes a 32-bit AXI4-Lite register bus and an 8-pin keypad port.
package keypad_wake_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam logic [11:0] OFF_PIN_ENABLE = 12'h000;
  localparam logic [11:0] OFF_AUX_CONTROL = 12'h004;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFF_PIN_LEVEL = 12'h010;
  localparam int unsigned AUX_IRQ_EN_BIT = 0;
  localparam int unsigned AUX_FLAG_BIT = 7;
  localparam int unsigned STAT_FLAG_BIT = 0;
  localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;
  localparam logic AUX_IRQ_EN_RESET = 1'b0;
  localparam logic IRQ_MASK_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned SYNC_STAGES = 2;
endpackage

// [inc/pin_sync_if.sv]
// Carries synchronised keypad pin levels from the synchroniser to the controller.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if #(parameter int unsigned WIDTH = 8);
  logic [WIDTH-1:0] level;
  modport source (output level);
  modport sink   (input  level);
endinterface
`default_nettype wire

// [src/pin_synchronizer.sv]
// Two-stage synchroniser for the asynchronous keypad pins.
// Assumes pins may change at any time relative to clk.
`timescale 1ns/1ns
`default_nettype none
module pin_synchronizer #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [WIDTH-1:0] pins,
  pin_sync_if.source      sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;
  sync_s state_q;
  sync_s state_d;

  // Pins idle high, so reset to the released level to avoid a false press
  always_comb begin
    state_d        = state_q;
    state_d.meta   = pins;
    state_d.stable = state_q.meta; // R8
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync.level = state_q.stable;
endmodule // pin_synchronizer
`default_nettype wire

// [dv/keypad_switches.sv]
// Keypad switches on the far side: a pressed key pulls its pin low.
// Assumes pull-ups on every line of the port.
`timescale 1ns/1ns
`default_nettype none
module keypad_switches (
  input  wire logic [7:0] press,
  output logic      [7:0] pins
);
  // Released lines sit at the pull-up level, never at a stale value
  assign pins = ~press;
endmodule // keypad_switches
`default_nettype wire

// [dv/keypad_sva.sv]
// Checker bound to the keypad wake block's top ports.
// Assumes one clock; rst_n is the raw reset pin.
`timescale 1ns/1ns
`default_nettype none
module keypad_sva #(parameter int unsigned PINS = 8) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic [PINS-1:0] keypad_pins,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            irq,
  input wire logic            wake_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Wake is registered from the same next-state irq, so it can never lag irq
  AST_IRQ_WAKES: assert property (irq |-> wake_request) else $error("irq without wake");
  AST_WAKE: assert property (wake_request |-> irq || $past(irq) || !(&$past(keypad_pins)))
    else $error("wake without cause");
  // A register write changes irq at the edge that raises bvalid
  AST_SRC: assert property ($rose(irq) |-> s_axi_bvalid || !(&$past(keypad_pins,3)))
    else $error("irq rose without cause");
  AST_STICKY: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("irq fell alone");
  AST_HOLD: assert property (irq |=> irq || s_axi_bvalid) else $error("irq dropped");
  AST_AW_HELD: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw while b");
  AST_AR_HELD: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar while r");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property ($rose(wake_request) && !irq);
endmodule // keypad_sva
bind keypad_wake_interrupt keypad_sva #(.PINS(PINS)) sva (.clk(clk), .rst_n(rst_n),
  .keypad_pins(keypad_pins), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .irq(irq),
  .wake_request(wake_request));
`default_nettype wire

// [dv/testbench.sv]
// Bench: AXI4-Lite master, keypad model, one task per scenario.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0;
  logic        rr = 1'b0, awr, wrd, bv, arr, rv, irq, wake;
  logic [7:0]  press = 8'h00, pins;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000, rdata, rdv;
  logic [1:0]  rresp, resp, bresp_w, brs;
  int          fails = 0, samples_checked = 0;
  always #5 clk = ~clk;
  keypad_switches keys (.press(press), .pins(pins));
  keypad_wake_interrupt dut (.clk(clk), .rst_n(rst_n), .keypad_pins(pins), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp_w), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .irq(irq), .wake_request(wake));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    {awv, wv, br} <= 3'b111;
    do begin
      @(posedge clk);
      if (awr && awv) awv <= 1'b0;
      if (wrd && wv) wv <= 1'b0;
      if (bv && br) {brs, br} <= {bresp_w, 1'b0};
    end while (awv || wv || br);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    ara <= a;
    {arv, rr} <= 2'b11;
    do begin
      @(posedge clk);
      if (arr && arv) arv <= 1'b0;
      if (rv && rr) {rdv, resp, rr} <= {rdata, rresp, 1'b0};
    end while (arv || rr);
    chk(nm, e, rdv);
  endtask
  task automatic t_gate_mask;
    rd("hole", 12'h020, 32'h0000_0000);
    chk("rresp", keypad_wake_pkg::RESP_SLVERR, resp);
    wr(12'h000, 32'h0000_00FF);
    press <= 8'h08;
    repeat (6) @(posedge clk);
    rd("aux", 12'h004, 32'h0000_0000);
    wr(12'h004, 32'h0000_0001);
    repeat (6) @(posedge clk);
    // Mask resets to zero, so the flag is only recorded
    chk("irq", 32'h0000_0000, irq);
    rd("aux", 12'h004, 32'h0000_0081);
    wr(12'h00C, 32'h0000_0001);
    chk("irq", 32'h0000_0001, irq);
    press <= 8'h00;
  endtask
  task automatic t_pins;
    for (int n = 0; n < 8; n++) begin
      wr(12'h000, 32'h0000_0001 << n);
      wr(12'h008, 32'h0000_0001);
      press <= 8'h01 << ((n + 1) % 8);
      repeat (6) @(posedge clk);
      rd("aux", 12'h004, 32'h0000_0001);
      press <= 8'h01 << n;
      repeat (6) @(posedge clk);
      chk("irq", 32'h0000_0001, irq);
      press <= 8'h00;
      repeat (6) @(posedge clk);
      rd("aux", 12'h004, 32'h0000_0081);
    end
  endtask
  task automatic t_wake_clear;
    wr(12'h00C, 32'h0000_0000);
    wr(12'h000, 32'h0000_0010);
    wr(12'h008, 32'h0000_0001);
    chk("bresp", keypad_wake_pkg::RESP_OKAY, brs);
    press <= 8'h10;
    @(posedge clk);
    @(posedge clk);
    // Raw pin path wakes one edge after the press, before the synchroniser
    chk("wake", 32'h0000_0001, wake);
    chk("irq", 32'h0000_0000, irq);
    repeat (4) @(posedge clk);
    rd("level", 12'h010, 32'h0000_00EF);
    // Clearing through bit 7 while the key is still down: the press wins
    wr(12'h004, 32'h0000_0001);
    rd("aux", 12'h004, 32'h0000_0081);
    press <= 8'h00;
    repeat (4) @(posedge clk);
    wr(12'h004, 32'h0000_0001);
    rd("aux", 12'h004, 32'h0000_0001);
    chk("wake", 32'h0000_0000, wake);
    wr(12'h020, 32'h0000_0001);
    chk("bresp", keypad_wake_pkg::RESP_SLVERR, brs);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd("enable", 12'h000, 32'h0000_0000);
    rd("aux", 12'h004, 32'h0000_0000);
    chk("irq", 32'h0000_0000, irq);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_gate_mask;
    t_pins;
    t_wake_clear;
    wrap_up;
  end
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
